// [core/wmc_seq.sv]
// Purpose: Modem control line sequencer for one WAN port
// Assumes: Modem lines are level signals, active high at this port
// Notes:   Timers count a one-second tick; carrier wait is an input
//
// What this block does
// - Transmit never gated by clear-to-send
// - Ring answered by raising DTR and RTS
// - Wait programmable interval for carrier and DSR
// - Leased line ignores ring, answers on carrier
// - No carrier in time: drop lines 5 s
// - Raise, wait, drop cycle repeats while inactive
// - Ring during low period raises lines at once
// - Layer-two timeout starts the toggle cycle
// - Link up only with carrier and DSR
// - Carrier absent 10 s while up: alarm
// - Ring with DTR high restarts wait timer
// - Ring ignored once carrier and DSR are received
// - Backup mode holds secondary DTR, RTS low
// - Backup activation raises DTR and RTS

`timescale 1ns/100ps

module wmc_seq
  import wmc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire wmc_lines_t modem_i,
  input  wire logic [7:0] carrier_wait_sec_i,
  input  wire logic       leased_mode_i,
  input  wire logic       backup_mode_i,
  input  wire logic       backup_activate_i,
  input  wire logic       l2_timeout_i,
  output wmc_ctl_t        ctl_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  wmc_lines_t sync1_ff;
  wmc_lines_t sync2_ff;
  wmc_lines_t nxt_sync1;
  wmc_lines_t nxt_sync2;

  always_comb begin
    nxt_sync1 = modem_i;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_ff <= LINES_RST;
      sync2_ff <= LINES_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic ring_s;
  logic cd_s;
  logic dsr_s;
  assign ring_s = sync2_ff.ring;
  assign cd_s   = sync2_ff.carrier;
  assign dsr_s  = sync2_ff.dsr;

  // ---------------------------------------------------------------
  // State, tick and seconds counters
  // ---------------------------------------------------------------
  wmc_state_t        state_ff;
  wmc_state_t        nxt_state;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [TICK_W-1:0] nxt_tick_cnt;
  logic [7:0]        sec_ff;
  logic [7:0]        nxt_sec;
  wmc_ctl_t          ctl_ff;
  wmc_ctl_t          nxt_ctl;
  logic              tick;
  logic              sec_clr;
  logic              block;
  logic              answer;
  logic [7:0]        wait_lim;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  assign tick  = (tick_cnt_ff == TICK_LAST);
  assign block = backup_mode_i && !backup_activate_i;
  assign answer = leased_mode_i ? cd_s : ring_s;
  // programmable carrier wait
  // Zero would wrap to a 256 s wait, so it acts as one second
  assign wait_lim = (carrier_wait_sec_i == 8'h00) ? SEC_ONE : carrier_wait_sec_i;

  always_comb begin
    nxt_state = state_ff;
    sec_clr   = 1'b0;
    if (block) begin
      nxt_state = WMC_ST_BACKUP;
    end else begin
      unique case (state_ff)
        WMC_ST_BACKUP: begin
          nxt_state = WMC_ST_WAIT;
        end
        WMC_ST_LOW: begin
          if (answer) begin
            nxt_state = WMC_ST_WAIT;
          end else if (tick && (sec_ff == LOW_SEC - SEC_ONE)) begin
            nxt_state = WMC_ST_WAIT;
          end
        end
        WMC_ST_WAIT: begin
          if (l2_timeout_i) begin
            nxt_state = WMC_ST_LOW;
          end else if (cd_s && dsr_s) begin
            nxt_state = WMC_ST_UP;
          end else if (!leased_mode_i && ring_s) begin
            sec_clr = 1'b1;
          end else if (tick && (sec_ff == wait_lim - SEC_ONE)) begin
            nxt_state = WMC_ST_LOW;
          end
        end
        WMC_ST_UP: begin
          if (l2_timeout_i) begin
            nxt_state = WMC_ST_LOW;
          end else if (cd_s) begin
            sec_clr = 1'b1;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (sec_clr || (nxt_state != state_ff)) begin
      nxt_tick_cnt = '0;
      nxt_sec      = 8'h00;
    end else begin
      nxt_tick_cnt = tick ? '0 : tick_cnt_ff + TICK_W'(1);
      nxt_sec      = (tick && (sec_ff != SEC_MAX)) ? sec_ff + SEC_ONE : sec_ff;
    end
  end

  // Outputs follow next state so they move with the state register
  always_comb begin
    nxt_ctl         = CTL_RST;
    // DTR and RTS high while answering
    nxt_ctl.dtr     = (nxt_state == WMC_ST_WAIT) || (nxt_state == WMC_ST_UP);
    nxt_ctl.rts     = (nxt_state == WMC_ST_WAIT) || (nxt_state == WMC_ST_UP);
    nxt_ctl.link_up = (nxt_state == WMC_ST_UP);
    nxt_ctl.tx_en   = (nxt_state == WMC_ST_UP);
    nxt_ctl.alarm   = (state_ff == WMC_ST_UP) && (nxt_state == WMC_ST_UP) && !cd_s &&
                      (ctl_ff.alarm || (tick && (sec_ff == LOSS_SEC - SEC_ONE)));
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff    <= WMC_ST_LOW;
      tick_cnt_ff <= '0;
      sec_ff      <= 8'h00;
      ctl_ff      <= CTL_RST;
    end else begin
      state_ff    <= nxt_state;
      tick_cnt_ff <= nxt_tick_cnt;
      sec_ff      <= nxt_sec;
      ctl_ff      <= nxt_ctl;
    end
  end

  assign ctl_o = ctl_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_cts_free_tx: assert property (
    ctl_o.tx_en == ctl_o.link_up)
    else $error("transmit enable not tied to link state");

  a_ring_raises: assert property (
    (state_ff == WMC_ST_LOW) && ring_s && !leased_mode_i && !block
    |=> ctl_o.dtr && ctl_o.rts && (sec_ff == 8'h00))
    else $error("ring did not raise lines with fresh timer");

  a_wait_expiry: assert property (
    (state_ff == WMC_ST_WAIT) && tick && (sec_ff == wait_lim - SEC_ONE) &&
    !(cd_s && dsr_s) && !(ring_s && !leased_mode_i) && !block && !l2_timeout_i
    |=> !ctl_o.dtr && !ctl_o.rts)
    else $error("carrier wait expiry did not drop lines");

  a_leased_no_ring: assert property (
    leased_mode_i && (state_ff == WMC_ST_LOW) && ring_s && !cd_s && !block && !tick
    |=> state_ff == WMC_ST_LOW)
    else $error("leased line answered on ring");

  a_low_period: assert property (
    (state_ff == WMC_ST_LOW) && tick && (sec_ff == LOW_SEC - SEC_ONE) && !block
    |=> ctl_o.dtr && (state_ff == WMC_ST_WAIT))
    else $error("low period did not end in raise");

  a_l2_toggle: assert property (
    l2_timeout_i && !block &&
    ((state_ff == WMC_ST_WAIT) || (state_ff == WMC_ST_UP))
    |=> !ctl_o.dtr && !ctl_o.rts ##1 (!ctl_o.dtr || $past(answer)))
    else $error("layer-two timeout did not start toggle");

  a_up_needs_lines: assert property (
    $rose(ctl_o.link_up) |-> $past(cd_s) && $past(dsr_s))
    else $error("link up without carrier and dsr");

  a_alarm_ten: assert property (
    $rose(ctl_o.alarm) |-> $past(sec_ff) == LOSS_SEC - SEC_ONE && !$past(cd_s))
    else $error("alarm not after ten seconds of loss");

  a_ring_restart: assert property (
    (state_ff == WMC_ST_WAIT) && ring_s && !leased_mode_i && !(cd_s && dsr_s) &&
    !l2_timeout_i && !block
    |=> (sec_ff == 8'h00) && (tick_cnt_ff == '0))
    else $error("ring did not restart carrier wait");

  a_up_ring_ignored: assert property (
    (state_ff == WMC_ST_UP) && ring_s && !l2_timeout_i && !block
    |=> state_ff == WMC_ST_UP)
    else $error("ring disturbed an established link");

  a_backup_idle: assert property (
    block |=> !ctl_o.dtr && !ctl_o.rts && !ctl_o.link_up)
    else $error("backup link not held idle");

  a_backup_raise: assert property (
    (state_ff == WMC_ST_BACKUP) && !block |=> ctl_o.dtr && ctl_o.rts)
    else $error("backup activation did not raise lines");

  a_tick_single: assert property (
    tick |=> !tick)
    else $error("tick longer than one cycle");

  c_answer_up: cover property (
    (state_ff == WMC_ST_WAIT) ##[1:200] (state_ff == WMC_ST_UP));
  c_wait_expire: cover property (
    (state_ff == WMC_ST_WAIT) ##1 (state_ff == WMC_ST_LOW));
  c_alarm: cover property ($rose(ctl_o.alarm));
  c_backup_wake: cover property (
    (state_ff == WMC_ST_BACKUP) ##1 (state_ff == WMC_ST_WAIT));

endmodule

// [shared/wmc_pkg.sv]
// Purpose: Shared constants and types for the WAN modem control sequencer
// Assumes: 250 MHz system clock, seconds-scale timers
// Notes:   All counts derive from times held in their own units

package wmc_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 28;

  // ---------------------------------------------------------------
  // Intervals in seconds
  // ---------------------------------------------------------------
  localparam logic [7:0] WAIT_SEC_DEF = 8'h3c;
  localparam logic [7:0] LOW_SEC      = 8'h05;
  localparam logic [7:0] LOSS_SEC     = 8'h0a;
  localparam logic [7:0] SEC_MAX      = 8'hff;
  localparam logic [7:0] SEC_ONE      = 8'h01;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WMC_ST_LOW    = 2'h0,
    WMC_ST_WAIT   = 2'h1,
    WMC_ST_UP     = 2'h2,
    WMC_ST_BACKUP = 2'h3
  } wmc_state_t;

  // ---------------------------------------------------------------
  // Grouped line signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ring;
    logic carrier;
    logic dsr;
  } wmc_lines_t;

  localparam wmc_lines_t LINES_RST = '{ring: 1'b0, carrier: 1'b0, dsr: 1'b0};

  typedef struct packed {
    logic dtr;
    logic rts;
    logic link_up;
    logic tx_en;
    logic alarm;
  } wmc_ctl_t;

  localparam wmc_ctl_t CTL_RST = '{dtr: 1'b0, rts: 1'b0, link_up: 1'b0,
                                   tx_en: 1'b0, alarm: 1'b0};

endpackage

// [tb/test_wmc_seq.sv]
// Purpose: Self-checking bench for the modem control sequencer
// Assumes: One-second tick shortened to 10 clocks, wait of 2 s
// Notes:   Times are counted with a small slack for tick phase
`timescale 1ns/100ps

module test_wmc_seq
  import wmc_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       ring = 1'b0;
  logic       answer = 1'b0;
  logic       leased = 1'b0;
  logic       backup = 1'b0;
  logic       activate = 1'b0;
  logic       l2_to = 1'b0;
  logic       cd_drop = 1'b0;
  logic [7:0] wait_sec = 8'h02;
  wmc_lines_t lines;
  wmc_ctl_t   ctl;
  int         fail_count = 0;
  int         check_count = 0;
  int         n;

  always #2 clk_i = ~clk_i;

  wmc_seq #(.TICK_CYC(10)) i_wmc_seq (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .modem_i(lines), .carrier_wait_sec_i(wait_sec), .leased_mode_i(leased),
    .backup_mode_i(backup), .backup_activate_i(activate), .l2_timeout_i(l2_to),
    .ctl_o(ctl));

  wmc_modem_model i_wmc_modem_model (.clk_i(clk_i), .dtr_i(ctl.dtr), .rts_i(ctl.rts),
    .ring_i(ring), .answer_i(answer), .leased_i(leased), .cd_drop_i(cd_drop),
    .lines_o(lines));

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rng(string nm, int lo, int hi, int g);
    check_count++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge clk_i);
  endtask

  // Bounded wait on one control bit; running out ends the run
  task automatic wt(int b, logic v, int mx, output int k);
    k = 0;
    while (ctl[b] !== v) begin
      if (k == mx) begin
        fail_count++;
        $display("CHECK FAILED ctl bit %0d expected %b seen %b", b, v, ctl[b]);
        wrap_up();
      end
      cyc(1);
      k++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_poll();
    wt(4, 1'b1, 70, n);
    rng("low period", 47, 53, n);
    chk("rts up", 1'b1, ctl.rts);
    wt(4, 1'b0, 30, n);
    rng("carrier wait", 17, 23, n);
    chk("rts down", 1'b0, ctl.rts);
    $display("test poll done");
  endtask

  task automatic t_ring();
    cyc(10);
    ring = 1'b1;
    wt(4, 1'b1, 5, n);
    chk("rts on ring", 1'b1, ctl.rts);
    ring = 1'b0;
    cyc(15);
    ring = 1'b1;
    cyc(3);
    ring = 1'b0;
    cyc(15);
    chk("dtr held", 1'b1, ctl.dtr);
    wt(4, 1'b0, 12, n);
    ring = 1'b1;
    cyc(4);
    ring = 1'b0;
    answer = 1'b1;
    wt(2, 1'b1, 10, n);
    chk("tx_en", 1'b1, ctl.tx_en);
    $display("test ring done");
  endtask

  task automatic t_loss();
    ring = 1'b1;
    cyc(6);
    ring = 1'b0;
    chk("up after ring", 1'b1, ctl.link_up);
    cd_drop = 1'b1;
    cyc(88);
    chk("alarm early", 1'b0, ctl.alarm);
    chk("link kept", 1'b1, ctl.link_up);
    wt(0, 1'b1, 20, n);
    cd_drop = 1'b0;
    wt(0, 1'b0, 5, n);
    l2_to = 1'b1;
    cyc(1);
    l2_to = 1'b0;
    wt(4, 1'b0, 3, n);
    chk("link down", 1'b0, ctl.link_up);
    $display("test loss done");
  endtask

  task automatic t_backup();
    backup = 1'b1;
    cyc(60);
    chk("idle dtr", 1'b0, ctl.dtr);
    chk("idle rts", 1'b0, ctl.rts);
    activate = 1'b1;
    wt(4, 1'b1, 3, n);
    wt(2, 1'b1, 10, n);
    activate = 1'b0;
    wt(4, 1'b0, 3, n);
    $display("test backup done");
  endtask

  task automatic t_leased();
    answer = 1'b0;
    leased = 1'b1;
    backup = 1'b0;
    cyc(3);
    l2_to = 1'b1;
    cyc(1);
    l2_to = 1'b0;
    ring = 1'b1;
    cyc(8);
    chk("ring ignored", 1'b0, ctl.dtr);
    ring = 1'b0;
    answer = 1'b1;
    wt(4, 1'b1, 6, n);
    wt(2, 1'b1, 8, n);
    $display("test leased done");
  endtask

  // Other wait settings, zero as one second, then reset mid-run
  task automatic t_wait_set();
    leased = 1'b0;
    answer = 1'b0;
    wait_sec = 8'h03;
    l2_to = 1'b1;
    cyc(1);
    l2_to = 1'b0;
    ring = 1'b1;
    wt(4, 1'b1, 5, n);
    ring = 1'b0;
    wt(4, 1'b0, 40, n);
    rng("wait three", 29, 35, n);
    wait_sec = 8'h00;
    wt(4, 1'b1, 60, n);
    wt(4, 1'b0, 20, n);
    rng("wait zero", 8, 12, n);
    wt(4, 1'b1, 60, n);
    sys_rst_i = 1'b1;
    cyc(2);
    chk("reset drops dtr", 1'b0, ctl.dtr);
    sys_rst_i = 1'b0;
    wt(4, 1'b1, 70, n);
    rng("low after reset", 47, 53, n);
    $display("test wait setting done");
  endtask

  initial begin
    cyc(4);
    sys_rst_i = 1'b0;
    chk("reset dtr", 1'b0, ctl.dtr);
    t_poll();
    t_ring();
    t_loss();
    t_backup();
    t_leased();
    t_wait_set();
    wrap_up();
  end
endmodule

// [tb/wmc_modem_model.sv]
// Purpose: Behavioural modem facing the sequencer
// Assumes: Carrier and DSR follow the call one cycle late
// Notes:   Answers only when told; hangs up when DTR or RTS drops, unless leased
`timescale 1ns/100ps

module wmc_modem_model
  import wmc_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  dtr_i,
  input  wire logic  rts_i,
  input  wire logic  ring_i,
  input  wire logic  answer_i,
  input  wire logic  leased_i,
  input  wire logic  cd_drop_i,
  output wmc_lines_t lines_o
);
  // ---------------------------------------------------------------
  // Call state
  // ---------------------------------------------------------------
  logic conn_ff;
  logic nxt_conn;

  always_comb begin
    nxt_conn = answer_i && ((dtr_i && rts_i) || leased_i);
  end

  always_ff @(posedge clk_i) begin
    conn_ff <= nxt_conn;
  end

  assign lines_o = '{ring: ring_i, carrier: conn_ff && !cd_drop_i, dsr: conn_ff};
endmodule
